// file: itb_defines.vh
// Constants for the instruction tag and breakpoint block
`ifndef ITB_DEFINES_VH
`define ITB_DEFINES_VH

// Timing
`define ITB_CLK_PERIOD_NS  100
`define ITB_E_PERIOD_NS    800
`define ITB_E_DIV_CYC      (`ITB_E_PERIOD_NS / `ITB_CLK_PERIOD_NS)
`define ITB_E_QUARTER_CYC  (`ITB_E_DIV_CYC / 4)
`define ITB_E_HALF_CYC     (`ITB_E_DIV_CYC / 2)

// Queue
`define ITB_QUEUE_DEPTH    2

// Breakpoint mode encodings {sel_1, sel_0}
`define ITB_MODE_OFF       2'h0
`define ITB_MODE_SWI_DUAL  2'h1
`define ITB_MODE_FULL      2'h2
`define ITB_MODE_BDM_DUAL  2'h3

// Value register select codes
`define ITB_SEL_ADDR_HIGH  2'h0
`define ITB_SEL_ADDR_LOW   2'h1
`define ITB_SEL_DATA_HIGH  2'h2
`define ITB_SEL_DATA_LOW   2'h3

// Reset values
`define ITB_BRK_RST        8'h00
`define ITB_TAG_NONE       2'h0

`endif

// file: itb_tag_breakpoint.v
// Instruction tagging, tag queue and low breakpoint data byte comparison
`timescale 1ns/1ps
`include "itb_defines.vh"

// Behaviour
// - Low data byte compares data or address
// - Mode, enable, range, mask steer low byte
// - Breakpoint value registers cleared only at power-on
// - Tag command switches two pins to tagging
// - Tags sampled at each E falling edge
// - Low pin tags its byte of word
// - Two tag pins act independently
// - Tagging any mode, stops on background mode
// - Serial commands blocked while tagging active
// - Tag pins share debug and strobe pins
// - Tags travel with bytes through queue
// - Tagged head instruction enters background mode
// - Range bit adds low byte to address
// - Low mask excludes low data byte
module itb_tag_breakpoint #(
    parameter E_DIV  = `ITB_E_DIV_CYC,
    parameter QDEPTH = `ITB_QUEUE_DEPTH
) (
    // Clock and resets
    input  wire        clk,
    input  wire        arst_n,
    input  wire        por_arst_n,
    // Breakpoint value register writes
    input  wire        brk_wr_en,
    input  wire [1:0]  brk_wr_sel,
    input  wire [7:0]  brk_wr_data,
    // Breakpoint control bits
    input  wire        brk_mode_sel_1,
    input  wire        brk_mode_sel_0,
    input  wire        brk_data_cmp_en,
    input  wire        bp1_full_addr_en,
    input  wire        brk_low_byte_mask,
    // CPU buses
    input  wire [15:0] addr_bus,
    input  wire [15:0] data_bus,
    // Debug control
    input  wire        tag_enable_cmd,
    input  wire        background_debug_mode,
    // Program fetch and queue
    input  wire        fetch_valid,
    input  wire        queue_adv,
    input  wire        opcode_start,
    input  wire        opcode_low_byte,
    input  wire        low_byte_strobe,
    // Pins
    input  wire        debug_serial_pin_in,
    output reg         debug_serial_pin_out,
    output reg         debug_serial_pin_oe_n,
    input  wire        port_e_bit3_in,
    output reg         port_e_bit3_out,
    output reg         port_e_bit3_oe_n,
    output reg         bus_e_clock,
    // Status and results
    output reg         tagging_active,
    output reg         serial_cmd_block,
    output reg         bdm_enter,
    output reg  [15:0] queue_head_word,
    output reg  [1:0]  queue_head_tag,
    output reg         queue_full,
    output reg         low_data_match,
    output reg         bp1_addr_match,
    output reg  [7:0]  brk_addr_high_reg,
    output reg  [7:0]  brk_addr_low_reg,
    output reg  [7:0]  brk_data_high_reg,
    output reg  [7:0]  brk_data_low_reg
);

    localparam          CW          = 4;
    // Count constants are cut to the counter widths on purpose
    localparam [31:0]   E_LAST_W    = E_DIV - 1;
    localparam [31:0]   E_FALL_W    = `ITB_E_HALF_CYC;
    localparam [31:0]   E_QUARTER_W = `ITB_E_QUARTER_CYC;
    localparam [31:0]   E_WIN_LO_W  = E_DIV - `ITB_E_QUARTER_CYC;
    localparam [31:0]   QDEPTH_W    = QDEPTH;
    localparam [7:0]    E_LAST      = E_LAST_W[7:0];
    localparam [7:0]    E_FALL      = E_FALL_W[7:0];
    localparam [7:0]    E_PRE_FALL  = E_FALL - 8'h01;
    localparam [7:0]    E_QUARTER   = E_QUARTER_W[7:0];
    localparam [7:0]    E_WIN_LO    = E_WIN_LO_W[7:0];
    localparam [CW-1:0] Q_FULL      = QDEPTH_W[CW-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Breakpoint value registers: only power-on reset clears them

    always @(posedge clk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            brk_addr_high_reg <= `ITB_BRK_RST;
            brk_addr_low_reg  <= `ITB_BRK_RST;
            brk_data_high_reg <= `ITB_BRK_RST;
            brk_data_low_reg  <= `ITB_BRK_RST;
        end else if (brk_wr_en) begin
            if (brk_wr_sel == `ITB_SEL_ADDR_HIGH) begin
                brk_addr_high_reg <= brk_wr_data;
            end else if (brk_wr_sel == `ITB_SEL_ADDR_LOW) begin
                brk_addr_low_reg <= brk_wr_data;
            end else if (brk_wr_sel == `ITB_SEL_DATA_HIGH) begin
                brk_data_high_reg <= brk_wr_data;
            end else begin
                brk_data_low_reg <= brk_wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Low data byte comparison

    wire [1:0] mode = {brk_mode_sel_1, brk_mode_sel_0};
    reg        nxt_low_data_match;
    reg        nxt_bp1_addr_match;

    always @* begin
        nxt_low_data_match = 1'b0;
        nxt_bp1_addr_match = 1'b0;
        if (mode == `ITB_MODE_FULL) begin
            // Disabled or masked low byte counts as matched so it never vetoes
            if (!brk_data_cmp_en || brk_low_byte_mask) begin
                nxt_low_data_match = 1'b1;
            end else begin
                nxt_low_data_match = (data_bus[7:0] == brk_data_low_reg);
            end
        end else if (mode == `ITB_MODE_SWI_DUAL || mode == `ITB_MODE_BDM_DUAL) begin
            // Here the data cmp enable turns on the second address breakpoint
            if (brk_data_cmp_en) begin
                if (bp1_full_addr_en) begin
                    nxt_bp1_addr_match = (addr_bus[15:8] == brk_data_high_reg) &&
                                         (addr_bus[7:0] == brk_data_low_reg);
                end else begin
                    nxt_bp1_addr_match = (addr_bus[15:8] == brk_data_high_reg);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // E clock divider and low strobe window

    reg  [7:0] e_cnt_ff;
    wire [7:0] nxt_e_cnt  = (e_cnt_ff == E_LAST) ? 8'h00 : e_cnt_ff + 8'h01;
    // Capture happens on the very edge at which bus_e_clock goes low
    wire       e_fall     = (e_cnt_ff == E_PRE_FALL);
    wire       nxt_e_high = (nxt_e_cnt < E_FALL);
    // Window spans a quarter E either side of the rising edge at count zero
    wire       nxt_win    = (nxt_e_cnt >= E_WIN_LO) || (nxt_e_cnt < E_QUARTER);

    ////////////////////////////////////////////////////////////////////////////
    // Tag pin synchronisers (three stages, second and third must agree)

    reg [2:0] tag_hi_sync_ff;
    reg [2:0] tag_lo_sync_ff;
    reg       tag_hi_n_ff;
    reg       tag_lo_n_ff;
    wire      tag_high_n = tag_hi_n_ff;
    wire      tag_low_n  = tag_lo_n_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Tagging control

    reg  nxt_tagging;
    always @* begin
        nxt_tagging = tagging_active;
        if (background_debug_mode) begin
            nxt_tagging = 1'b0;
        end else if (tag_enable_cmd) begin
            nxt_tagging = 1'b1;
        end
    end

    // Tags are captured per byte, each from its own pin only
    wire [1:0] cap_tag = {~tag_high_n, ~tag_low_n} & {2{tagging_active}};

    ////////////////////////////////////////////////////////////////////////////
    // Instruction queue with per-byte tags

    reg  [15:0]   q_word_ff [0:QDEPTH-1];
    reg  [1:0]    q_tag_ff  [0:QDEPTH-1];
    reg  [CW-1:0] q_cnt_ff;
    // A fetch arriving while full is dropped; the CPU never fetches that far ahead
    wire          push      = e_fall && fetch_valid && (q_cnt_ff < Q_FULL);
    wire          pop       = queue_adv && (q_cnt_ff != {CW{1'b0}});
    wire [CW-1:0] push_idx  = q_cnt_ff - {{(CW-1){1'b0}}, pop};
    wire [CW-1:0] nxt_q_cnt = q_cnt_ff + {{(CW-1){1'b0}}, push}
                                       - {{(CW-1){1'b0}}, pop};

    genvar gi;
    generate
        for (gi = 0; gi < QDEPTH; gi = gi + 1) begin : g_q
            reg [15:0] nxt_word;
            reg [1:0]  nxt_tag;
            always @* begin
                nxt_word = q_word_ff[gi];
                nxt_tag  = q_tag_ff[gi];
                if (pop) begin
                    if (gi + 1 < QDEPTH) begin
                        nxt_word = q_word_ff[(gi + 1) % QDEPTH];
                        nxt_tag  = q_tag_ff[(gi + 1) % QDEPTH];
                    end else begin
                        nxt_word = 16'h0000;
                        nxt_tag  = `ITB_TAG_NONE;
                    end
                end
                if (push && (push_idx == gi)) begin
                    nxt_word = data_bus;
                    nxt_tag  = cap_tag;
                end
            end
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    q_word_ff[gi] <= 16'h0000;
                    q_tag_ff[gi]  <= `ITB_TAG_NONE;
                end else begin
                    q_word_ff[gi] <= nxt_word;
                    q_tag_ff[gi]  <= nxt_tag;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next head entry, built alongside the queue so the head outputs stay registered

    reg [15:0] nxt_head_word;
    reg [1:0]  nxt_head_tag;
    always @* begin
        nxt_head_word = q_word_ff[0];
        nxt_head_tag  = q_tag_ff[0];
        if (pop) begin
            if (QDEPTH > 1) begin
                nxt_head_word = q_word_ff[1 % QDEPTH];
                nxt_head_tag  = q_tag_ff[1 % QDEPTH];
            end else begin
                nxt_head_word = 16'h0000;
                nxt_head_tag  = `ITB_TAG_NONE;
            end
        end
        if (push && (push_idx == {CW{1'b0}})) begin
            nxt_head_word = data_bus;
            nxt_head_tag  = cap_tag;
        end
    end

    // Tag of the byte the CPU is about to execute
    wire head_tagged = opcode_low_byte ? q_tag_ff[0][0] : q_tag_ff[0][1];
    wire nxt_bdm_enter = opcode_start && (q_cnt_ff != {CW{1'b0}}) &&
                         head_tagged && !background_debug_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Main registers

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            // One count short of zero, so the first E high phase is full length
            e_cnt_ff              <= E_LAST;
            bus_e_clock           <= 1'b0;
            tag_hi_sync_ff        <= 3'h7;
            tag_lo_sync_ff        <= 3'h7;
            tag_hi_n_ff           <= 1'b1;
            tag_lo_n_ff           <= 1'b1;
            tagging_active        <= 1'b0;
            serial_cmd_block      <= 1'b0;
            bdm_enter             <= 1'b0;
            q_cnt_ff              <= {CW{1'b0}};
            queue_head_word       <= 16'h0000;
            queue_head_tag        <= `ITB_TAG_NONE;
            queue_full            <= 1'b0;
            low_data_match        <= 1'b0;
            bp1_addr_match        <= 1'b0;
            debug_serial_pin_out  <= 1'b1;
            debug_serial_pin_oe_n <= 1'b1;
            port_e_bit3_out       <= 1'b0;
            port_e_bit3_oe_n      <= 1'b1;
        end else begin
            e_cnt_ff       <= nxt_e_cnt;
            bus_e_clock    <= nxt_e_high;
            tag_hi_sync_ff <= {tag_hi_sync_ff[1:0], debug_serial_pin_in};
            tag_lo_sync_ff <= {tag_lo_sync_ff[1:0], port_e_bit3_in};
            // Filter keeps the old level on disagreement, so short glitches are ignored
            if (tag_hi_sync_ff[1] == tag_hi_sync_ff[2]) begin
                tag_hi_n_ff <= tag_hi_sync_ff[2];
            end
            if (tag_lo_sync_ff[1] == tag_lo_sync_ff[2]) begin
                tag_lo_n_ff <= tag_lo_sync_ff[2];
            end
            tagging_active   <= nxt_tagging;
            serial_cmd_block <= nxt_tagging;
            bdm_enter        <= nxt_bdm_enter;
            q_cnt_ff         <= nxt_q_cnt;
            queue_head_word  <= nxt_head_word;
            queue_head_tag   <= nxt_head_tag;
            queue_full       <= (nxt_q_cnt == Q_FULL);
            low_data_match   <= nxt_low_data_match;
            bp1_addr_match   <= nxt_bp1_addr_match;
            // Debug pin is only an input here; tagging never drives it
            debug_serial_pin_out  <= 1'b1;
            debug_serial_pin_oe_n <= 1'b1;
            // Strobe driven only inside its window so the host can tag outside it
            port_e_bit3_out  <= low_byte_strobe;
            port_e_bit3_oe_n <= ~nxt_win;
        end
    end

endmodule // itb_tag_breakpoint

// file: itb_tag_host.sv
// Development system model driving the two tag pins
`timescale 1ns/1ps
module itb_tag_host (
    // Device drive of the shared pins
    input  logic dbg_out,
    input  logic dbg_oe_n,
    input  logic pe3_out,
    input  logic pe3_oe_n,
    // Levels seen at the pins
    output logic dbg_pin,
    output logic pe3_pin
);
    logic [1:0] want_n = 2'h3;
    // Undriven pins carry the host's want_n level; a high level means no tag
    assign dbg_pin = dbg_oe_n ? want_n[1] : dbg_out;
    // Host yields the strobe pin inside the strobe window
    assign pe3_pin = pe3_oe_n ? want_n[0] : pe3_out;
    // No serial command is sent while tags are in use
    task set_tags(input logic [1:0] t_n);
        want_n = t_n;
    endtask
endmodule // itb_tag_host

// file: itb_tag_breakpoint_monitor.sv
// Concurrent checks on the tag and breakpoint ports
`timescale 1ns/1ps
module itb_tag_breakpoint_monitor (
    // Clock, reset and inputs
    input logic        clk,
    input logic        arst_n,
    input logic        brk_mode_sel_1,
    input logic        brk_mode_sel_0,
    input logic        brk_data_cmp_en,
    input logic        bp1_full_addr_en,
    input logic        brk_low_byte_mask,
    input logic [15:0] addr_bus,
    input logic [15:0] data_bus,
    input logic        tag_enable_cmd,
    input logic        background_debug_mode,
    input logic        opcode_start,
    // Outputs
    input logic        port_e_bit3_oe_n,
    input logic        bus_e_clock,
    input logic        tagging_active,
    input logic        serial_cmd_block,
    input logic        bdm_enter,
    input logic        low_data_match,
    input logic        bp1_addr_match,
    input logic [7:0]  brk_data_high_reg,
    input logic [7:0]  brk_data_low_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_e_high; bus_e_clock[*4]; endsequence
    sequence s_e_low; !bus_e_clock[*4]; endsequence
    sequence s_drive; !port_e_bit3_oe_n[*2]; endsequence
    a_tag_start: assert property (
        tag_enable_cmd && !background_debug_mode |=> tagging_active)
        else $error("tagging did not start");
    a_bdm_stops: assert property (background_debug_mode |=> !tagging_active)
        else $error("tagging not stopped");
    a_cmd_block: assert property (serial_cmd_block == tagging_active)
        else $error("command block differs");
    a_e_shape: assert property ($rose(bus_e_clock) |-> s_e_high ##1 s_e_low ##1 bus_e_clock)
        else $error("bad e clock shape");
    a_strobe_win: assert property (
        $rose(bus_e_clock) |-> s_drive ##1 port_e_bit3_oe_n[*4] ##1 s_drive)
        else $error("bad strobe window");
    a_bdm_cause: assert property (
        bdm_enter |-> $past(opcode_start) && !$past(background_debug_mode))
        else $error("stray debug entry");
    a_low_cmp: assert property (
        brk_mode_sel_1 && !brk_mode_sel_0 && brk_data_cmp_en |=> low_data_match ==
        ($past(brk_low_byte_mask) || $past(data_bus[7:0]) == $past(brk_data_low_reg)))
        else $error("low data compare wrong");
    a_bp1_range: assert property (
        brk_mode_sel_0 && brk_data_cmp_en |=> bp1_addr_match ==
        ($past(addr_bus[15:8]) == $past(brk_data_high_reg) && (!$past(bp1_full_addr_en)
        || $past(addr_bus[7:0]) == $past(brk_data_low_reg))))
        else $error("address compare wrong");
endmodule // itb_tag_breakpoint_monitor

// file: test_itb_tag_breakpoint.sv
// Self-checking bench for the tag and breakpoint block
`timescale 1ns/1ps
module test_itb_tag_breakpoint;
    logic        clk, arst_n, por_arst_n, brk_wr_en, tag_enable_cmd, fetch_valid;
    logic        brk_mode_sel_1, brk_mode_sel_0, brk_data_cmp_en, bp1_full_addr_en;
    logic        brk_low_byte_mask, background_debug_mode, queue_adv, opcode_start;
    logic        opcode_low_byte, low_byte_strobe, tag_on, op_d;
    logic [1:0]  brk_wr_sel;
    logic [7:0]  brk_wr_data, rg[4];
    logic [15:0] addr_bus, data_bus;
    logic [31:0] seed, r;
    logic [50:0] notes[$];
    int          n_fail, n_tests;
    wire         debug_serial_pin_in, debug_serial_pin_out, debug_serial_pin_oe_n, bus_e_clock;
    wire         port_e_bit3_in, port_e_bit3_out, port_e_bit3_oe_n, tagging_active, bdm_enter;
    wire         serial_cmd_block, queue_full, low_data_match, bp1_addr_match;
    wire [1:0]   queue_head_tag;
    wire [15:0]  queue_head_word;
    wire [7:0]   brk_addr_high_reg, brk_addr_low_reg, brk_data_high_reg, brk_data_low_reg;
    itb_tag_breakpoint uut (.*);
    itb_tag_host host (.dbg_out(debug_serial_pin_out), .dbg_oe_n(debug_serial_pin_oe_n),
        .pe3_out(port_e_bit3_out), .pe3_oe_n(port_e_bit3_oe_n),
        .dbg_pin(debug_serial_pin_in), .pe3_pin(port_e_bit3_in));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic step();
        @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [50:0] seen, input logic [50:0] exp);
        n_tests++;
        if (seen !== exp) n_fail++;
        if (seen !== exp) $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic e_wait(input logic lvl);
        for (int n = 0; n < 20 && bus_e_clock !== lvl; n++) step();
    endtask
    // Pins held a whole E period before the capturing fall, to clear the pin filter
    task automatic trial(input logic [1:0] tn, input logic lo);
        logic [1:0] tg;
        tg = ~tn & {2{tag_on}};
        e_wait(1'b1);
        e_wait(1'b0);
        host.set_tags(tn);
        low_byte_strobe = tn[0];
        e_wait(1'b1);
        r = xs();
        {fetch_valid, data_bus} = {1'b1, r[15:0]};
        e_wait(1'b0);
        fetch_valid = 1'b0;
        step();
        {opcode_start, opcode_low_byte} = {1'b1, lo};
        notes.push_back({data_bus, rg[0], rg[1], rg[2], rg[3], tg,
            (lo ? tg[0] : tg[1]) & !background_debug_mode});
        step();
        {opcode_start, queue_adv} = 2'h1;
        host.set_tags(2'h3);
        step();
        queue_adv = 1'b0;
    endtask
    always @(posedge clk) begin
        if (op_d && notes.size() > 0)
            chk({queue_head_word, brk_addr_high_reg, brk_addr_low_reg, brk_data_high_reg,
                brk_data_low_reg,
                queue_head_tag, bdm_enter}, notes.pop_front());
        op_d <= opcode_start;
    end
    initial begin
        {arst_n, por_arst_n, brk_wr_en, tag_enable_cmd, fetch_valid, queue_adv} = '0;
        {opcode_start, opcode_low_byte, low_byte_strobe, background_debug_mode} = '0;
        {brk_mode_sel_1, brk_mode_sel_0, brk_data_cmp_en, bp1_full_addr_en} = '0;
        {brk_low_byte_mask, brk_wr_sel, brk_wr_data, addr_bus, data_bus} = '0;
        {tag_on, op_d, n_fail, n_tests} = '0;
        rg = '{default: 8'h00};
        seed = 32'h00014796;
        repeat (4) @(posedge clk);
        #2 {arst_n, por_arst_n} = 2'h3;
        trial(2'h0, 1'b0);
        repeat (300) begin
            r = xs();
            {brk_mode_sel_1, brk_mode_sel_0, brk_data_cmp_en, bp1_full_addr_en} = r[3:0];
            {brk_low_byte_mask, low_byte_strobe, brk_wr_en, brk_wr_sel} = r[8:4];
            brk_wr_data = r[31:24];
            if (brk_wr_en) rg[brk_wr_sel] = brk_wr_data;
            addr_bus = {r[9] ? rg[2] : r[23:16], r[10] ? rg[3] : r[15:8]};
            data_bus = {r[23:16], r[11] ? rg[3] : r[31:24]};
            step();
        end
        brk_wr_en = 1'b0;
        tag_enable_cmd = 1'b1;
        step();
        {tag_enable_cmd, tag_on} = 2'h1;
        for (int i = 0; i < 8; i++) trial(i[1:0], i[2]);
        {background_debug_mode, tag_enable_cmd} = 2'h3;
        step();
        {tag_enable_cmd, tag_on} = 2'h0;
        trial(2'h0, 1'b1);
        {background_debug_mode, tag_enable_cmd} = 2'h1;
        step();
        {tag_enable_cmd, tag_on} = 2'h1;
        trial(2'h2, 1'b0);
        arst_n = 1'b0;
        step();
        {arst_n, tag_on} = 2'h2;
        trial(2'h0, 1'b1);
        por_arst_n = 1'b0;
        step();
        por_arst_n = 1'b1;
        rg = '{default: 8'h00};
        trial(2'h0, 1'b0);
        give_verdict();
    end
    // About 520 cycles are needed; the limit leaves a wide margin
    initial begin
        #1000000;
        n_fail++;
        give_verdict();
    end
endmodule // test_itb_tag_breakpoint
bind itb_tag_breakpoint itb_tag_breakpoint_monitor mon (.*);
